// ### logic/haes_pkg.sv
package haes_pkg;

   // Control register field layout
   localparam int EVT_LSB  = 0;
   localparam int EVT_MSB  = 7;
   localparam int UMSK_LSB = 8;
   localparam int UMSK_MSB = 15;
   localparam int CTL_W    = 18;
   localparam int CTR_W    = 48;
   localparam int NUM_CTR  = 4;
   localparam int NUM_CHAN = 4;
   localparam int NUM_REG  = 11;
   localparam int INC_W    = 3;

   // Register offsets: control n at 2n, counter n at 2n+1
   localparam logic [3:0] OFS_CTL0 = 4'h0;
   localparam logic [3:0] OFS_CTR0 = 4'h1;
   localparam logic [3:0] OFS_STEP = 4'h2;

   localparam logic [CTL_W-1:0] CTL_RST = 18'h00000;
   localparam logic [CTR_W-1:0] CTR_RST = 48'h000000000000;

   // Event codes
   localparam logic [7:0] EV_REQUESTS   = 8'h01;
   localparam logic [7:0] EV_DIR_LOOKUP = 8'h0C;
   localparam logic [7:0] EV_DIR_UPDATE = 8'h0D;
   localparam logic [7:0] EV_BYP_OFF    = 8'h12;
   localparam logic [7:0] EV_BYP_OVR    = 8'h13;
   localparam logic [7:0] EV_RPQ_STARVE = 8'h15;
   localparam logic [7:0] EV_MEM_WRITES = 8'h1A;
   localparam logic [7:0] EV_REGION_LO  = 8'h1B;
   localparam logic [7:0] EV_REGION_HI  = 8'h1C;
   localparam logic [7:0] EV_LINK_STARV = 8'h22;

   // Per-cycle maxima
   localparam logic [INC_W-1:0] MAX_ONE  = 3'h1;
   localparam logic [INC_W-1:0] MAX_TWO  = 3'h2;
   localparam logic [INC_W-1:0] MAX_FOUR = 3'h4;

   // Request opcode classes
   typedef enum logic [1:0] {
      HAES_REQ_NONE  = 2'b00,
      HAES_REQ_READ  = 2'b01,
      HAES_REQ_WRITE = 2'b10
   } haes_req_e;

   typedef enum logic [2:0] {
      HAES_OP_RD     = 3'b000,
      HAES_OP_RD_OWN = 3'b001,
      HAES_OP_WR_STR = 3'b010,
      HAES_OP_WR_EVC = 3'b011,
      HAES_OP_WR_HTM = 3'b100,
      HAES_OP_WR_OTH = 3'b101
   } haes_op_e;

   // Raw activity from the home agent, one cycle each
   typedef struct packed {
      logic                bypass_off;
      logic                bypass_override;
      logic                dir_lookup_snp;
      logic                dir_lookup_nosnp;
      logic                remote_read_fill;
      logic                snoops_all_invalid;
      logic [3:0]          link_no_credit;
      logic [3:0]          mem_write;
      logic [NUM_CHAN-1:0] rpq_reg_empty;
      logic [NUM_CHAN-1:0] rpq_iso_empty;
      logic                req_valid;
      logic [2:0]          req_opcode;
      logic [1:0]          mem_req_valid;
      logic [7:0]          mem_req_addr0;
      logic [7:0]          mem_req_addr1;
   } haes_act_s;

   // Region decode table entry
   typedef struct packed {
      logic [7:0] base;
      logic [7:0] limit;
   } haes_region_s;

endpackage

// ### logic/haes_event_counter.sv
`timescale 1ns/10ps
module haes_event_counter
   import haes_pkg::*;
#(
   parameter int WIDTH = haes_pkg::CTR_W
) (
   input  wire logic                      mclk,
   input  wire logic                      srst,
   input  wire logic                      load,
   input  wire logic [WIDTH-1:0]          load_val,
   input  wire logic [haes_pkg::INC_W-1:0] inc,
   output logic      [WIDTH-1:0]          count
);

   // -----------------------------------------
   // Counter, wraps on carry out of top bit
   // -----------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         count <= CTR_RST[WIDTH-1:0];
      end else if (load) begin
         count <= load_val;
      end else begin
         count <= count + WIDTH'(inc);
      end
   end

endmodule

// ### logic/haes_top.sv
`timescale 1ns/10ps
module haes_top
   import haes_pkg::*;
#(
   parameter bit DIR_PRESENT = 1'b1,
   parameter int NUM_CTR_P   = haes_pkg::NUM_CTR,
   parameter int NUM_REGION  = haes_pkg::NUM_REG
) (
   input  wire logic                     mclk,
   input  wire logic                     srst,
   input  wire logic [3:0]               reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [31:0]              reg_rdata,
   input  wire haes_pkg::haes_act_s      act,
   input  wire haes_pkg::haes_region_s [NUM_REGION-1:0] region_map,
   output logic      [NUM_CTR_P*haes_pkg::CTR_W-1:0] count_flat,
   output logic      [1:0]               req_class,
   output logic      [NUM_CHAN-1:0]      rd_send_ok
);
   import haes_pkg::*;

   // -----------------------------------------
   // Control registers
   // -----------------------------------------
   logic [CTL_W-1:0]     ctl [NUM_CTR_P];
   logic [CTR_W-1:0]     cnt [NUM_CTR_P];
   logic [NUM_CTR_P-1:0] ctr_load;
   logic [INC_W-1:0]     inc [NUM_CTR_P];
   logic [2:0]           ctr_idx;
   logic                 ctr_hi;

   assign ctr_idx = reg_addr[3:1];
   assign ctr_hi  = reg_addr[0];

   always_ff @(posedge mclk) begin
      for (int i = 0; i < NUM_CTR_P; i++) begin
         if (srst) begin
            ctl[i] <= CTL_RST;
         end else if (reg_wr && !ctr_hi && int'(ctr_idx) == i) begin
            ctl[i] <= reg_wdata[CTL_W-1:0];
         end
      end
   end

   // Counter preload, write data to low word, high 16 bits cleared
   always_comb begin
      for (int i = 0; i < NUM_CTR_P; i++) begin
         ctr_load[i] = reg_wr && ctr_hi && int'(ctr_idx) == i;
      end
   end

   // -----------------------------------------
   // Pipelined activity sources
   // -----------------------------------------
   haes_act_s            act_q;
   logic [1:0]           req_cls_q;
   logic [3:0]           reg_hit_q [2];
   logic [1:0]           reg_ok_q;
   logic [NUM_CHAN-1:0]  rpq_starve;
   logic [1:0]           dir_upd;

   always_ff @(posedge mclk) begin
      if (srst) begin
         act_q <= '0;
      end else begin
         act_q <= act;
      end
   end

   function automatic logic [1:0] classify(input logic [2:0] op);
      logic [1:0] c;
      c = HAES_REQ_NONE;
      case (op)
         HAES_OP_RD, HAES_OP_RD_OWN: c = HAES_REQ_READ;
         HAES_OP_WR_STR, HAES_OP_WR_EVC,
         HAES_OP_WR_HTM, HAES_OP_WR_OTH: c = HAES_REQ_WRITE;
         default: c = HAES_REQ_NONE;
      endcase
      return c;
   endfunction

   always_ff @(posedge mclk) begin
      if (srst) begin
         req_cls_q <= HAES_REQ_NONE;
      end else begin
         req_cls_q <= act.req_valid ? classify(act.req_opcode)
                                    : HAES_REQ_NONE;
      end
   end

   // Decode result when no region matches
   localparam logic [4:0] NO_REGION = 5'h1F;

   // decode each memory request to a region
   function automatic logic [4:0] decode(
      input logic [7:0] a,
      input haes_region_s [NUM_REGION-1:0] m
   );
      logic [4:0] r;
      r = NO_REGION;
      for (int k = NUM_REGION - 1; k >= 0; k--) begin
         if (a >= m[k].base && a <= m[k].limit) begin
            r = 5'(k);
         end
      end
      return r;
   endfunction

   logic [4:0] reg_id [2];
   always_comb begin
      reg_id[0] = decode(act.mem_req_addr0, region_map);
      reg_id[1] = decode(act.mem_req_addr1, region_map);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_hit_q[0] <= 4'h0;
         reg_hit_q[1] <= 4'h0;
      end else begin
         for (int j = 0; j < 2; j++) begin
            reg_hit_q[j] <= reg_id[j][3:0];
         end
      end
   end

   // request outside every region counts nowhere
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_ok_q <= 2'b00;
      end else begin
         for (int j = 0; j < 2; j++) begin
            reg_ok_q[j] <= act.mem_req_valid[j] && reg_id[j] != NO_REGION;
         end
      end
   end

   // regular pool only; special pool ignored
   assign rpq_starve = act_q.rpq_reg_empty;

   assign dir_upd = {act_q.snoops_all_invalid, act_q.remote_read_fill};

   // -----------------------------------------
   // Sub-events, bit n answers unit-mask bit n
   // -----------------------------------------
   logic [7:0] sub_lookup;
   logic [7:0] sub_update;
   logic [7:0] sub_link;
   logic [7:0] sub_write;
   logic [7:0] sub_req;
   logic [7:0] sub_starve;

   // snoop needed on bit 0, none on bit 1
   assign sub_lookup = {6'h00, act_q.dir_lookup_nosnp,
                        act_q.dir_lookup_snp};
   // set on bit 0, clear on bit 1
   assign sub_update = {6'h00, dir_upd};
   assign sub_link   = {4'h0, act_q.link_no_credit};
   assign sub_write  = {4'h0, act_q.mem_write};
   // reads on bits 1:0, writes 3:2
   assign sub_req    = {4'h0, {2{req_cls_q[1]}}, {2{req_cls_q[0]}}};
   assign sub_starve = {4'h0, rpq_starve};

   // -----------------------------------------
   // Subevent sum per counter
   // -----------------------------------------
   // selected sub-events summed
   function automatic logic [INC_W-1:0] popcnt8(input logic [7:0] v);
      logic [INC_W:0] s;
      s = '0;
      for (int b = 0; b < 8; b++) begin
         s = s + {{INC_W{1'b0}}, v[b]};
      end
      return (s > {1'b0, MAX_FOUR}) ? MAX_FOUR : s[INC_W-1:0];
   endfunction

   function automatic logic [INC_W-1:0] cap(
      input logic [INC_W-1:0] v,
      input logic [INC_W-1:0] m
   );
      return (v > m) ? m : v;
   endfunction

   function automatic logic [INC_W-1:0] region_count(
      input logic [1:0] ok,
      input logic [3:0] h0,
      input logic [3:0] h1,
      input logic [7:0] um,
      input logic       hi
   );
      logic [INC_W-1:0] s;
      logic [3:0] h [2];
      s = '0;
      h[0] = h0;
      h[1] = h1;
      for (int j = 0; j < 2; j++) begin
         if (ok[j] && (h[j][3] == hi) && um[h[j][2:0]]) begin
            s = s + 3'h1;
         end
      end
      return s;
   endfunction

   // every counter sees the full event set
   always_comb begin
      for (int i = 0; i < NUM_CTR_P; i++) begin
         logic [7:0] ev;
         logic [7:0] um;
         ev = ctl[i][EVT_MSB:EVT_LSB];
         um = ctl[i][UMSK_MSB:UMSK_LSB];
         inc[i] = '0;
         case (ev)
            EV_BYP_OFF: inc[i] = {2'b00, act_q.bypass_off};
            EV_BYP_OVR: inc[i] = {2'b00, act_q.bypass_override};
            EV_DIR_LOOKUP: begin
               inc[i] = DIR_PRESENT ? cap(popcnt8(sub_lookup & um),
                                          MAX_ONE) : '0;
            end
            EV_DIR_UPDATE: begin
               inc[i] = DIR_PRESENT ? cap(popcnt8(sub_update & um),
                                          MAX_ONE) : '0;
            end
            EV_LINK_STARV: inc[i] = cap(popcnt8(sub_link & um), MAX_ONE);
            EV_MEM_WRITES: inc[i] = cap(popcnt8(sub_write & um), MAX_ONE);
            EV_REQUESTS: inc[i] = cap(popcnt8(sub_req & um), MAX_ONE);
            EV_RPQ_STARVE: inc[i] = popcnt8(sub_starve & um);
            EV_REGION_LO: inc[i] = cap(region_count(reg_ok_q,
               reg_hit_q[0], reg_hit_q[1], um, 1'b0), MAX_TWO);
            EV_REGION_HI: inc[i] = cap(region_count(reg_ok_q,
               reg_hit_q[0], reg_hit_q[1], um, 1'b1), MAX_TWO);
            default: inc[i] = '0;
         endcase
      end
   end

   // -----------------------------------------
   // Counters
   // -----------------------------------------
   // 48-bit wrapping counters
   for (genvar g = 0; g < NUM_CTR_P; g++) begin : g_ctr
      haes_event_counter #(
         .WIDTH (CTR_W)
      ) u_ctr (
         .mclk     (mclk),
         .srst     (srst),
         .load     (ctr_load[g]),
         .load_val ({16'h0000, reg_wdata}),
         .inc      (inc[g]),
         .count    (cnt[g])
      );
   end

   // -----------------------------------------
   // Read port and status outputs
   // -----------------------------------------
   // counts readable while running
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h00000000;
         for (int i = 0; i < NUM_CTR_P; i++) begin
            if (int'(ctr_idx) == i) begin
               reg_rdata <= ctr_hi ? cnt[i][31:0]
                                   : {14'h0000, ctl[i]};
            end
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         count_flat <= '0;
      end else begin
         for (int i = 0; i < NUM_CTR_P; i++) begin
            count_flat[i*CTR_W +: CTR_W] <= cnt[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         req_class <= HAES_REQ_NONE;
      end else begin
         req_class <= req_cls_q;
      end
   end

   // reads may go only where a regular credit exists
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_send_ok <= '0;
      end else begin
         rd_send_ok <= ~act.rpq_reg_empty;
      end
   end

endmodule

// ### dv/haes_chk.sv
`timescale 1ns/10ps
module haes_chk
   import haes_pkg::*;
#(
   parameter int NUM_CTR_P  = haes_pkg::NUM_CTR,
   parameter int NUM_REGION = haes_pkg::NUM_REG
) (
   input wire logic                                mclk,
   input wire logic                                srst,
   input wire logic [3:0]                          reg_addr,
   input wire logic [31:0]                         reg_wdata,
   input wire logic                                reg_wr,
   input wire logic                                reg_rd,
   input wire logic [31:0]                         reg_rdata,
   input wire haes_pkg::haes_act_s                 act,
   input wire haes_pkg::haes_region_s [NUM_REGION-1:0] region_map,
   input wire logic [NUM_CTR_P*haes_pkg::CTR_W-1:0] count_flat,
   input wire logic [1:0]                          req_class,
   input wire logic [NUM_CHAN-1:0]                 rd_send_ok
);
   // Shadow of counter 0 selection
   logic [15:0]      sel0;
   wire logic [47:0] cnt0 = count_flat[CTR_W-1:0];
   always_ff @(posedge mclk) begin
      if (srst) begin
         sel0 <= 16'h0000;
      end else if (reg_wr && reg_addr == OFS_CTL0) begin
         sel0 <= reg_wdata[15:0];
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_quiet;
      !reg_wr [*2];
   endsequence
   property p_step(logic c, logic [2:0] d);
      c && !reg_wr ##1 s_quiet |=> cnt0 == $past(cnt0) + 48'(d);
   endproperty
   AST_BYP_OFF: assert property (p_step(
      sel0[7:0] == EV_BYP_OFF && act.bypass_off, 3'h1))
      else $error("bypass-off cycle not counted");
   AST_BYP_IDLE: assert property (p_step(
      sel0[7:0] == EV_BYP_OFF && !act.bypass_off, 3'h0))
      else $error("idle cycle counted");
   AST_BYP_OVR: assert property (p_step(
      sel0[7:0] == EV_BYP_OVR && act.bypass_override, 3'h1))
      else $error("overridden read not counted");
   AST_RPQ_ALL: assert property (p_step(
      sel0 == {8'h0F, EV_RPQ_STARVE} && act.rpq_reg_empty == 4'hF, 3'h4))
      else $error("four starved channels not added");
   AST_RPQ_ISO: assert property (p_step(
      sel0[7:0] == EV_RPQ_STARVE && act.rpq_reg_empty == 4'h0, 3'h0))
      else $error("special pool counted");
   AST_REQ_RD: assert property (
      act.req_valid && act.req_opcode < 3'h2 |-> ##2 req_class == 2'h1)
      else $error("read opcode misclassified");
   AST_REQ_WR: assert property (
      act.req_valid && act.req_opcode inside {[3'h2:3'h5]}
      |-> ##2 req_class == 2'h2)
      else $error("write opcode misclassified");
   AST_SEND_OK: assert property (
      act.rpq_reg_empty == 4'h0 && act.rpq_iso_empty == 4'hF
      |=> rd_send_ok == 4'hF)
      else $error("read credit not granted");
endmodule

// ### dv/test_home_agent_event_select.sv
`timescale 1ns/10ps
module test_home_agent_event_select;
   import haes_pkg::*;
   logic                       mclk        = 1'h0;
   logic                       srst        = 1'h1;
   logic [3:0]                 reg_addr    = 4'h0;
   logic [31:0]                reg_wdata   = 32'h0;
   logic                       reg_wr      = 1'h0;
   logic                       reg_rd      = 1'h0;
   logic [31:0]                reg_rdata;
   haes_act_s                  act         = '0;
   haes_region_s [NUM_REG-1:0] region_map;
   logic [NUM_CTR*CTR_W-1:0]   count_flat;
   logic [1:0]                 req_class;
   logic [NUM_CHAN-1:0]        rd_send_ok;
   logic [31:0]                preload     = 32'h0;
   int                         miscompares = 0;
   int                         check_count = 0;
   always #5 mclk = ~mclk;
   haes_top haes_top_inst (
      .mclk       (mclk),
      .srst       (srst),
      .reg_addr   (reg_addr),
      .reg_wdata  (reg_wdata),
      .reg_wr     (reg_wr),
      .reg_rd     (reg_rd),
      .reg_rdata  (reg_rdata),
      .act        (act),
      .region_map (region_map),
      .count_flat (count_flat),
      .req_class  (req_class),
      .rd_send_ok (rd_send_ok)
   );
   // ----
   // Tasks
   // ----
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge mclk);
      reg_wr    <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge mclk);
      reg_rd   <= 1'h0;
      #1 d = reg_rdata;
   endtask
   // Select, load, stimulate, then read back both views
   task automatic run_ev(input int c, input logic [7:0] code,
         input logic [7:0] um, input haes_act_s a, input int n,
         input logic [47:0] exp);
      logic [31:0] d;
      logic [1:0]  cls;
      cls = !a.req_valid ? 2'h0 : (a.req_opcode < 3'h2) ? 2'h1
          : (a.req_opcode < 3'h6) ? 2'h2 : 2'h0;
      wr(4'(2 * c), {16'h0, um, code});
      wr(4'(2 * c + 1), preload);
      repeat (n) begin
         @(posedge mclk);
         act <= a;
      end
      @(posedge mclk);
      act <= '0;
      #1;
      check(rd_send_ok, {~a.rpq_reg_empty});
      check(req_class, cls);
      repeat (4) @(posedge mclk);
      rd(4'(2 * c + 1), d);
      check(d, exp[31:0]);
      check(count_flat[c*CTR_W +: CTR_W], exp);
   endtask
   task automatic complete_run();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
   initial begin
      haes_act_s   a;
      logic [31:0] d;
      for (int i = 0; i < NUM_REG; i++) begin
         region_map[i].base  = 8'(16 * i);
         region_map[i].limit = 8'(16 * i + 15);
      end
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      wr(4'h2, 32'h0000A51B);
      rd(4'h2, d);
      check(d, 32'h0000A51B);
      wr(4'h9, 32'h5);
      rd(4'h9, d);
      check(d, 32'h0);
      a = '0;
      a.bypass_off = 1'h1;
      run_ev(0, EV_BYP_OFF, 8'h00, a, 5, 48'h5);
      a = '0;
      a.bypass_override = 1'h1;
      for (int c = 0; c < 4; c++) begin
         run_ev(c, EV_BYP_OVR, 8'h00, a, 3 + c, 48'(3 + c));
      end
      a = '0;
      a.dir_lookup_snp = 1'h1;
      run_ev(1, EV_DIR_LOOKUP, 8'h01, a, 4, 48'h4);
      run_ev(1, EV_DIR_LOOKUP, 8'h02, a, 4, 48'h0);
      a.dir_lookup_nosnp = 1'h1;
      run_ev(1, EV_DIR_LOOKUP, 8'h03, a, 4, 48'h4);
      a = '0;
      a.remote_read_fill = 1'h1;
      run_ev(2, EV_DIR_UPDATE, 8'h01, a, 3, 48'h3);
      run_ev(2, EV_DIR_UPDATE, 8'h02, a, 3, 48'h0);
      a.snoops_all_invalid = 1'h1;
      run_ev(2, EV_DIR_UPDATE, 8'h03, a, 3, 48'h3);
      for (int i = 0; i < 4; i++) begin
         a = '0;
         a.link_no_credit = 4'(1 << i);
         run_ev(3, EV_LINK_STARV, 8'(1 << i), a, 2, 48'h2);
         run_ev(3, EV_LINK_STARV, 8'h0F ^ 8'(1 << i), a, 2, 48'h0);
         a = '0;
         a.mem_write = 4'(1 << i);
         run_ev(0, EV_MEM_WRITES, 8'(1 << i), a, 2, 48'h2);
      end
      a = '0;
      a.mem_write = 4'hF;
      run_ev(0, EV_MEM_WRITES, 8'h0F, a, 3, 48'h3);
      for (int op = 0; op < 8; op++) begin
         a = '0;
         a.req_valid = 1'h1;
         a.req_opcode = 3'(op);
         run_ev(1, EV_REQUESTS, 8'h03, a, 2,
            (op < 2) ? 48'h2 : 48'h0);
         run_ev(1, EV_REQUESTS, 8'h0C, a, 2,
            (op > 1 && op < 6) ? 48'h2 : 48'h0);
      end
      a = '0;
      a.rpq_reg_empty = 4'hF;
      run_ev(0, EV_RPQ_STARVE, 8'h0F, a, 3, 48'hC);
      run_ev(0, EV_RPQ_STARVE, 8'h05, a, 3, 48'h6);
      a.rpq_reg_empty = 4'h0;
      a.rpq_iso_empty = 4'hF;
      run_ev(0, EV_RPQ_STARVE, 8'h0F, a, 3, 48'h0);
      a = '0;
      a.mem_req_valid = 2'h3;
      a.mem_req_addr0 = 8'h05;
      a.mem_req_addr1 = 8'h25;
      run_ev(3, EV_REGION_LO, 8'hFF, a, 3, 48'h6);
      run_ev(3, EV_REGION_LO, 8'h04, a, 3, 48'h3);
      run_ev(3, EV_REGION_LO, 8'h02, a, 3, 48'h0);
      a.mem_req_addr0 = 8'h85;
      a.mem_req_addr1 = 8'hA5;
      run_ev(3, EV_REGION_HI, 8'h01, a, 3, 48'h3);
      run_ev(3, EV_REGION_HI, 8'h05, a, 3, 48'h6);
      run_ev(3, EV_REGION_LO, 8'hFF, a, 3, 48'h0);
      a.mem_req_valid = 2'h2;
      run_ev(3, EV_REGION_HI, 8'h05, a, 3, 48'h3);
      a = '0;
      a.bypass_off = 1'h1;
      preload = 32'hFFFFFFFE;
      run_ev(0, EV_BYP_OFF, 8'h00, a, 3, 48'h100000001);
      complete_run();
   end
endmodule
bind haes_top haes_chk #(
   .NUM_CTR_P  (NUM_CTR_P),
   .NUM_REGION (NUM_REGION)
) haes_chk_inst (
   .mclk       (mclk),
   .srst       (srst),
   .reg_addr   (reg_addr),
   .reg_wdata  (reg_wdata),
   .reg_wr     (reg_wr),
   .reg_rd     (reg_rd),
   .reg_rdata  (reg_rdata),
   .act        (act),
   .region_map (region_map),
   .count_flat (count_flat),
   .req_class  (req_class),
   .rd_send_ok (rd_send_ok)
);
